// file: core/rx_pin_ctrl.sv
// Control register, interrupt status and two buffer-full pin drivers
//
// Operation
// - Bit 5 sets buffer-one pin level, used only in digital output mode.
// - Bit 5 reads zero while buffer-one pin is in interrupt mode.
// - Bit 4 sets buffer-zero pin level, used only in digital output mode.
// - Bit 4 reads zero while buffer-zero pin is in interrupt mode.
// - Bit 3 enables buffer-one pin; its mode bit picks the function.
// - Bit 2 enables buffer-zero pin; its mode bit picks the function.
// - A cleared enable bit puts that pin in high impedance.
// - Bit 1 set: buffer-one pin is a message interrupt; clear: digital output.
// - Bit 0 set: buffer-zero pin is a message interrupt; clear: digital output.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "rx_pin_map.svh"
module rx_pin_ctrl (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register port
  input wire rx_pin_pkg::addr_t i_addr,
  input wire rx_pin_pkg::reg8_t i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output rx_pin_pkg::reg8_t o_rdata,
  // Events from receive buffers
  input wire logic i_buf0_loaded,
  input wire logic i_buf1_loaded,
  // Pins
  output logic o_rx_buf0_full_pin,
  output logic o_rx_buf0_full_pin_oe,
  output logic o_rx_buf1_full_pin,
  output logic o_rx_buf1_full_pin_oe,
  // Interrupt
  output logic o_irq
);
  import rx_pin_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [5:0] ctrl;
    logic [1:0] rx_full;
    logic [1:0] status;
    logic [1:0] mask;
    reg8_t rdata;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  pin_mode_t mode0;
  pin_mode_t mode1;
  logic [1:0] loaded;

  assign loaded = {i_buf1_loaded, i_buf0_loaded};

  // Control readback hides the level bit of a pin in interrupt mode
  function automatic reg8_t ctrl_view(input logic [5:0] c);
    reg8_t v;
    v = {2'b00, c};
    if (c[`BIT_B1_MODE]) begin
      v[`BIT_B1_LEVEL] = 1'b0;
    end
    if (c[`BIT_B0_MODE]) begin
      v[`BIT_B0_LEVEL] = 1'b0;
    end
    return v;
  endfunction

  always_comb begin
    reg8_t wmask;
    wmask = `PIN_CTRL_WMASK;
    st_nxt = st_r;
    st_nxt.rdata = `UNMAPPED_READ;
    if (i_write && i_addr == `ADDR_PIN_CTRL) begin
      st_nxt.ctrl = i_wdata[5:0] & wmask[5:0];
    end
    // Software clears a full flag by writing one; a new message wins
    if (i_write && i_addr == `ADDR_RX_FLAGS) begin
      st_nxt.rx_full = st_r.rx_full & ~i_wdata[1:0];
    end
    st_nxt.rx_full = st_nxt.rx_full | loaded;
    if (i_write && i_addr == `ADDR_IRQ_STATUS) begin
      st_nxt.status = st_r.status & ~i_wdata[1:0];
    end
    st_nxt.status = st_nxt.status | loaded;
    if (i_write && i_addr == `ADDR_IRQ_MASK) begin
      st_nxt.mask = i_wdata[1:0];
    end
    if (i_read) begin
      if (i_addr == `ADDR_PIN_CTRL) begin
        st_nxt.rdata = ctrl_view(st_r.ctrl);
      end else if (i_addr == `ADDR_IRQ_STATUS) begin
        st_nxt.rdata = {6'h00, st_r.status};
      end else if (i_addr == `ADDR_IRQ_MASK) begin
        st_nxt.rdata = {6'h00, st_r.mask};
      end else if (i_addr == `ADDR_RX_FLAGS) begin
        st_nxt.rdata = {6'h00, st_r.rx_full};
      end else begin
        st_nxt.rdata = `UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{ctrl: 6'h00, rx_full: 2'b00, status: 2'b00, mask: 2'b00, rdata: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_irq = |(st_r.status & st_r.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  rx_pin_drv u_pin0 (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_enable(st_r.ctrl[`BIT_B0_EN]),
    .i_mode_select(st_r.ctrl[`BIT_B0_MODE]),
    .i_level(st_r.ctrl[`BIT_B0_LEVEL]),
    .i_buf_full(st_r.rx_full[0]),
    .o_pin(o_rx_buf0_full_pin),
    .o_pin_oe(o_rx_buf0_full_pin_oe),
    .o_mode(mode0)
  );

  rx_pin_drv u_pin1 (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_enable(st_r.ctrl[`BIT_B1_EN]),
    .i_mode_select(st_r.ctrl[`BIT_B1_MODE]),
    .i_level(st_r.ctrl[`BIT_B1_LEVEL]),
    .i_buf_full(st_r.rx_full[1]),
    .o_pin(o_rx_buf1_full_pin),
    .o_pin_oe(o_rx_buf1_full_pin_oe),
    .o_mode(mode1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Steps of the interrupt-pin life cycle; the pin lags the flag by one register stage
  sequence seq_pin0_irq;
    st_r.ctrl[`BIT_B0_EN] && st_r.ctrl[`BIT_B0_MODE];
  endsequence

  sequence seq_pin1_irq;
    st_r.ctrl[`BIT_B1_EN] && st_r.ctrl[`BIT_B1_MODE];
  endsequence

  sequence seq_load0;
    st_r.ctrl[`BIT_B0_EN] && st_r.ctrl[`BIT_B0_MODE] && i_buf0_loaded ##1 seq_pin0_irq;
  endsequence

  sequence seq_load1;
    st_r.ctrl[`BIT_B1_EN] && st_r.ctrl[`BIT_B1_MODE] && i_buf1_loaded ##1 seq_pin1_irq;
  endsequence

  sequence seq_clear0;
    i_write && i_addr == `ADDR_RX_FLAGS && i_wdata[0] && !i_buf0_loaded
    && st_r.ctrl[`BIT_B0_EN] && st_r.ctrl[`BIT_B0_MODE] ##1 seq_pin0_irq;
  endsequence

  sequence seq_clear1;
    i_write && i_addr == `ADDR_RX_FLAGS && i_wdata[1] && !i_buf1_loaded
    && st_r.ctrl[`BIT_B1_EN] && st_r.ctrl[`BIT_B1_MODE] ##1 seq_pin1_irq;
  endsequence

  chk_top_bits_zero: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    $past(i_read) && $past(i_addr) == `ADDR_PIN_CTRL |-> o_rdata[7:6] == 2'b00)
    else $error("unimplemented bits read nonzero");

  chk_level1_out: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    mode1 == PIN_LEVEL |=> o_rx_buf1_full_pin == $past(st_r.ctrl[`BIT_B1_LEVEL]))
    else $error("pin one level wrong");

  chk_level0_out: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    mode0 == PIN_LEVEL |=> o_rx_buf0_full_pin == $past(st_r.ctrl[`BIT_B0_LEVEL]))
    else $error("pin zero level wrong");

  chk_irq1_hidden: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_read && i_addr == `ADDR_PIN_CTRL && st_r.ctrl[`BIT_B1_MODE] |=> !o_rdata[5])
    else $error("bit 5 visible in interrupt mode");

  chk_irq0_hidden: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_read && i_addr == `ADDR_PIN_CTRL && st_r.ctrl[`BIT_B0_MODE] |=> !o_rdata[4])
    else $error("bit 4 visible in interrupt mode");

  chk_level_readback: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_read && i_addr == `ADDR_PIN_CTRL && !st_r.ctrl[`BIT_B1_MODE] && !st_r.ctrl[`BIT_B0_MODE]
    |=> o_rdata == {2'b00, $past(st_r.ctrl)})
    else $error("stored levels not read back");

  chk_en1_drive: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    st_r.ctrl[`BIT_B1_EN] |=> o_rx_buf1_full_pin_oe)
    else $error("pin one enabled but not driven");

  chk_en0_drive: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    st_r.ctrl[`BIT_B0_EN] |=> o_rx_buf0_full_pin_oe)
    else $error("pin zero enabled but not driven");

  chk_pin_hiz: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    !st_r.ctrl[`BIT_B0_EN] ##1 !st_r.ctrl[`BIT_B0_EN] |-> !o_rx_buf0_full_pin_oe)
    else $error("disabled pin driven");

  chk_pin1_hiz: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    !st_r.ctrl[`BIT_B1_EN] ##1 !st_r.ctrl[`BIT_B1_EN] |-> !o_rx_buf1_full_pin_oe)
    else $error("disabled pin one driven");

  chk_irq1_mode: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    seq_load1 |=> !o_rx_buf1_full_pin)
    else $error("pin one did not signal message");

  chk_irq0_mode: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    seq_load0 |=> !o_rx_buf0_full_pin)
    else $error("pin zero did not signal message");

  chk_release_on_clear: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    seq_clear0 |=> o_rx_buf0_full_pin)
    else $error("pin zero not released");

  chk_release1_clear: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    seq_clear1 |=> o_rx_buf1_full_pin)
    else $error("pin one not released");

  chk_irq_pin_idle: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    st_r.ctrl[`BIT_B0_EN] && st_r.ctrl[`BIT_B0_MODE] && !st_r.rx_full[0]
    |=> o_rx_buf0_full_pin && o_rx_buf0_full_pin_oe)
    else $error("idle interrupt pin not released");

  chk_ctrl_write: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_write && i_addr == `ADDR_PIN_CTRL |=> st_r.ctrl == $past(i_wdata[5:0]))
    else $error("control write lost");

  chk_mask_write: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_write && i_addr == `ADDR_IRQ_MASK |=> st_r.mask == $past(i_wdata[1:0]))
    else $error("mask write lost");

  chk_rdata_quiet: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    !i_read |=> o_rdata == `UNMAPPED_READ)
    else $error("read data without a read");

  chk_unmapped_zero: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_read && i_addr > `ADDR_RX_FLAGS |=> o_rdata == `UNMAPPED_READ)
    else $error("unmapped read nonzero");

  chk_status_read: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_read && i_addr == `ADDR_IRQ_STATUS |=> o_rdata == {6'h00, $past(st_r.status)})
    else $error("status read wrong");

  chk_flag0_set_wins: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_buf0_loaded |=> st_r.rx_full[0] && st_r.status[0])
    else $error("buffer zero event lost");

  chk_flag1_set_wins: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_buf1_loaded |=> st_r.rx_full[1] && st_r.status[1])
    else $error("buffer one event lost");

  chk_flag_clear: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_write && i_addr == `ADDR_RX_FLAGS && i_wdata[0] && !i_buf0_loaded |=> !st_r.rx_full[0])
    else $error("full flag not cleared");

  chk_status_clear: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_write && i_addr == `ADDR_IRQ_STATUS && i_wdata[0] && !i_buf0_loaded |=> !st_r.status[0])
    else $error("status bit not cleared");

  chk_irq_raise: assert property (
    @(posedge i_clock) disable iff (!rst_n)
    i_buf0_loaded && st_r.mask[0] && !(i_write && i_addr == `ADDR_IRQ_MASK) |=> o_irq)
    else $error("unmasked event did not raise interrupt");
endmodule // rx_pin_ctrl

// file: core/rx_pin_map.svh
// Offsets, bit positions, reset values, write mask and unmapped read value for the buffer-full pin block
`ifndef RX_PIN_MAP_SVH
`define RX_PIN_MAP_SVH
`define ADDR_PIN_CTRL 8'h00
`define ADDR_IRQ_STATUS 8'h01
`define ADDR_IRQ_MASK 8'h02
`define ADDR_RX_FLAGS 8'h03
`define BIT_B0_MODE 0
`define BIT_B1_MODE 1
`define BIT_B0_EN 2
`define BIT_B1_EN 3
`define BIT_B0_LEVEL 4
`define BIT_B1_LEVEL 5
`define PIN_CTRL_RESET 8'h00
`define PIN_CTRL_WMASK 8'h3F
`define IRQ_MASK_RESET 8'h00
`define UNMAPPED_READ 8'h00
`endif

// file: core/rx_pin_pkg.sv
// Types shared by the buffer-full pin block
package rx_pin_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [7:0] addr_t;
  typedef enum logic [1:0] {
    PIN_OFF = 2'b00,
    PIN_LEVEL = 2'b01,
    PIN_IRQ = 2'b10
  } pin_mode_t;
endpackage

// file: core/rx_pin_drv.sv
// One buffer-full output pin: tristate, digital level or active-low interrupt
`timescale 1ns/1ps
module rx_pin_drv
  import rx_pin_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Configuration
  input wire logic i_enable,
  input wire logic i_mode_select,
  input wire logic i_level,
  // Buffer state
  input wire logic i_buf_full,
  // Pin
  output logic o_pin,
  output logic o_pin_oe,
  output rx_pin_pkg::pin_mode_t o_mode
);
  import rx_pin_pkg::*;

  typedef struct packed {
    logic pin;
    logic oe;
  } drv_state_t;

  drv_state_t st_r;
  drv_state_t st_nxt;
  pin_mode_t mode;

  always_comb begin
    if (!i_enable) begin
      mode = PIN_OFF;
    end else if (i_mode_select) begin
      mode = PIN_IRQ;
    end else begin
      mode = PIN_LEVEL;
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (mode)
      PIN_OFF: begin
        st_nxt.oe = 1'b0;
        st_nxt.pin = 1'b1;
      end
      PIN_IRQ: begin
        st_nxt.oe = 1'b1;
        st_nxt.pin = ~i_buf_full;
      end
      default: begin
        st_nxt.oe = 1'b1;
        st_nxt.pin = i_level;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{pin: 1'b1, oe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pin = st_r.pin;
  assign o_pin_oe = st_r.oe;
  assign o_mode = mode;

  chk_off_tristate: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !i_enable |=> !o_pin_oe)
    else $error("disabled pin still driven");
  chk_irq_low: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_enable && i_mode_select && i_buf_full) |=> (o_pin_oe && !o_pin))
    else $error("interrupt pin not low on full buffer");
endmodule // rx_pin_drv

// file: testbench/rx_host_model.sv
// Host model sampling both buffer-full pins
`timescale 1ns/1ps
module rx_host_model (
  // Clock
  input wire logic i_clock,
  // Pins
  input wire logic [1:0] i_pin,
  input wire logic [1:0] i_pin_oe,
  // Sampled wire level
  output logic [1:0] o_seen
);
  // A released pin shows the inverse of the last level it was driven to, so stale data
  // never passes for a fresh value; nothing pulls it either way
  logic [1:0] last_r;
  always_ff @(posedge i_clock) begin
    last_r <= (i_pin_oe & i_pin) | (~i_pin_oe & last_r);
    o_seen <= (i_pin_oe & i_pin) | (~i_pin_oe & ~last_r);
  end
endmodule // rx_host_model

// file: testbench/rx_pin_ctrl_test.sv
// Self-checking bench for the buffer-full pin control block
`timescale 1ns/1ps
module rx_pin_ctrl_test;
  import rx_pin_pkg::*;
  logic i_clock = 0, i_rstn = 0, i_write = 0, i_read = 0;
  logic i_buf0_loaded = 0, i_buf1_loaded = 0, rd_d = 0;
  addr_t i_addr = 8'h00;
  reg8_t i_wdata = 8'h00, o_rdata, d;
  logic p0, p0_oe, p1, p1_oe, o_irq;
  logic [1:0] seen;
  reg8_t exp_q[$];
  reg8_t dirs[4] = '{8'hFF, 8'h3C, 8'h33, 8'h00};
  int num_errors = 0, check_count = 0, cycles = 0, seed = 32'h0658;
  initial forever #20 i_clock = ~i_clock;
  rx_pin_ctrl DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_buf0_loaded(i_buf0_loaded), .i_buf1_loaded(i_buf1_loaded),
    .o_rx_buf0_full_pin(p0), .o_rx_buf0_full_pin_oe(p0_oe),
    .o_rx_buf1_full_pin(p1), .o_rx_buf1_full_pin_oe(p1_oe), .o_irq(o_irq));
  rx_host_model host (.i_clock(i_clock), .i_pin({p1, p0}), .i_pin_oe({p1_oe, p0_oe}),
    .o_seen(seen));
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic compare(input reg8_t got, input reg8_t exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each strobe is assigned once per edge, so back-to-back cycles never collide
  task automatic op(input logic w, input addr_t a, input reg8_t v);
    i_write <= w;
    i_read <= ~w;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
  endtask
  task automatic idle(input int n);
    i_write <= 1'b0;
    i_read <= 1'b0;
    repeat (n) @(posedge i_clock);
  endtask
  task automatic rd(input addr_t a, input reg8_t e);
    exp_q.push_back(e);
    op(1'b0, a, 8'h00);
  endtask
  task automatic check_pins(input logic [1:0] eo, input logic [1:0] el, input logic ei);
    idle(5);
    @(negedge i_clock);
    compare({6'h00, p1_oe, p0_oe}, {6'h00, eo});
    compare({6'h00, seen & eo}, {6'h00, el & eo});
    compare({7'h00, o_irq}, {7'h00, ei});
    @(posedge i_clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clock) begin
    rd_d <= i_read;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      close_out();
    end
  end
  always @(negedge i_clock) begin
    if (rd_d) compare(o_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    idle(3);
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h07, 8'h00);
    check_pins(2'b00, 2'b00, 1'b0);
    $display("test reset done");
    for (int k = 0; k < 14; k++) begin
      d = (k < 4) ? dirs[k] : $random(seed);
      op(1'b1, 8'h00, d);
      rd(8'h00, d & 8'h3F & ~{2'b00, d[1:0], 4'h0});
      check_pins({d[3], d[2]}, {d[1] | d[5], d[0] | d[4]}, 1'b0);
    end
    $display("test config done");
    op(1'b1, 8'h00, 8'h3F);
    op(1'b1, 8'h02, 8'h03);
    i_buf0_loaded <= 1'b1;
    i_buf1_loaded <= 1'b1;
    op(1'b0, 8'h05, 8'h00);
    i_buf0_loaded <= 1'b0;
    i_buf1_loaded <= 1'b0;
    exp_q.push_back(8'h00);
    check_pins(2'b11, 2'b00, 1'b1);
    rd(8'h01, 8'h03);
    rd(8'h03, 8'h03);
    op(1'b1, 8'h03, 8'h01);
    check_pins(2'b11, 2'b01, 1'b1);
    op(1'b1, 8'h02, 8'h00);
    check_pins(2'b11, 2'b01, 1'b0);
    op(1'b1, 8'h01, 8'h03);
    op(1'b1, 8'h02, 8'h03);
    check_pins(2'b11, 2'b01, 1'b0);
    op(1'b1, 8'h03, 8'h02);
    check_pins(2'b11, 2'b11, 1'b0);
    rd(8'h02, 8'h03);
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    idle(2);
    $display("test interrupt done");
    i_rstn <= 1'b0;
    idle(2);
    i_rstn <= 1'b1;
    idle(3);
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    check_pins(2'b00, 2'b00, 1'b0);
    $display("test second reset done");
    close_out();
  end
endmodule // rx_pin_ctrl_test
